/* File: logic/pscr_if.sv */
// Two-wire open-drain link joining the sensor end and the master end
interface pscr_if;
   logic scl;
   logic sda;
   logic scl_s_o;
   logic scl_s_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl_m_o;
   logic scl_m_oe;
   logic sda_m_o;
   logic sda_m_oe;

   // Wired-AND with pull-up
   assign scl = ~((scl_s_oe & ~scl_s_o) | (scl_m_oe & ~scl_m_o));
   assign sda = ~((sda_s_oe & ~sda_s_o) | (sda_m_oe & ~sda_m_o));

   modport sensor (
      input scl,
      input sda,
      output scl_s_o,
      output scl_s_oe,
      output sda_s_o,
      output sda_s_oe
   );

   modport master (
      input scl,
      input sda,
      output scl_m_o,
      output scl_m_oe,
      output sda_m_o,
      output sda_m_oe
   );
endinterface : pscr_if

/* File: logic/pscr_master.sv */
// Master end: drives SCL from CLK, writes commands and reads results
`include "pscr_params.svh"

module pscr_master (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic REQ_VALID,
   input wire logic REQ_READ,
   input wire logic [7:0] REQ_CMD,
   output logic REQ_READY,
   output logic DONE,
   output logic NACK,
   output logic signed [15:0] RESULT,
   output logic CRC_OK,
   pscr_if.master BUS
);
   localparam logic [7:0] QTR_LAST = 8'(`PSCR_QTR_CYC - 1);
   pscr_pkg::pscr_master_t m_q;
   pscr_pkg::pscr_master_t m_d;
   logic rx_byte;
   logic last_byte;

   assign rx_byte = m_q.rd && m_q.byte_n != 2'h0;
   assign last_byte = m_q.byte_n == (m_q.rd ? `PSCR_RD_LAST_BYTE : `PSCR_WR_LAST_BYTE);
   assign BUS.scl_m_o = 1'b0;
   assign BUS.sda_m_o = 1'b0;
   assign BUS.scl_m_oe = m_q.scl_oe;
   assign BUS.sda_m_oe = m_q.sda_oe;
   assign REQ_READY = m_q.state == pscr_pkg::MS_IDLE;
   assign DONE = m_q.done;
   assign NACK = m_q.nack;
   assign RESULT = m_q.result;
   assign CRC_OK = m_q.crc_ok;

   always_comb begin
      m_d = m_q;
      m_d.scl_m = BUS.scl;
      m_d.scl_s = m_q.scl_m;
      m_d.sda_m = BUS.sda;
      m_d.sda_s = m_q.sda_m;
      m_d.done = 1'b0;
      if (!RESET_N) begin
         m_d = '0;
         m_d.state = pscr_pkg::MS_IDLE;
      end else if (m_q.state == pscr_pkg::MS_IDLE) begin
         if (REQ_VALID) begin
            m_d.state = pscr_pkg::MS_START;
            m_d.phase = 2'h0;
            m_d.cnt = QTR_LAST;
            m_d.rd = REQ_READ;
            m_d.cmd = REQ_CMD;
            m_d.sh = {`PSCR_ADDR_DEFAULT, REQ_READ};
            m_d.byte_n = 2'h0;
            m_d.bit_n = 4'h0;
            m_d.nack = 1'b0;
         end
      end else if (m_q.cnt != 8'h00) begin
         m_d.cnt = m_q.cnt - 8'h01;
      end else begin
         m_d.cnt = QTR_LAST;
         m_d.phase = m_q.phase + 2'h1;
         unique case (m_q.state)
            pscr_pkg::MS_IDLE: begin
            end
            pscr_pkg::MS_START: begin
               if (m_q.phase == 2'h0) begin
                  m_d.sda_oe = 1'b1;
               end else begin
                  m_d.scl_oe = 1'b1;
                  m_d.phase = 2'h0;
                  m_d.state = pscr_pkg::MS_BIT;
               end
            end
            pscr_pkg::MS_BIT: begin
               unique case (m_q.phase)
                  2'h0: begin
                     if (m_q.bit_n == `PSCR_BYTE_BITS) begin
                        m_d.sda_oe = rx_byte && !last_byte;
                     end else begin
                        m_d.sda_oe = !rx_byte && !m_q.sh[7];
                     end
                  end
                  2'h1: m_d.scl_oe = 1'b0;
                  2'h2: begin
                     if (!m_q.scl_s) begin
                        m_d.cnt = 8'h00;
                        m_d.phase = m_q.phase;
                     end else if (m_q.bit_n != `PSCR_BYTE_BITS) begin
                        if (rx_byte) begin
                           m_d.sh = {m_q.sh[6:0], m_q.sda_s};
                        end
                     end else if (!rx_byte && m_q.sda_s) begin
                        m_d.nack = 1'b1;
                     end
                  end
                  2'h3: begin
                     m_d.scl_oe = 1'b1;
                     if (m_q.bit_n != `PSCR_BYTE_BITS) begin
                        if (!rx_byte) begin
                           m_d.sh = {m_q.sh[6:0], 1'b0};
                        end
                        m_d.bit_n = m_q.bit_n + 4'h1;
                     end else begin
                        if (rx_byte) begin
                           m_d.data = {m_q.data[15:0], m_q.sh};
                        end
                        if (m_q.nack || last_byte) begin
                           m_d.state = pscr_pkg::MS_STOP;
                        end else begin
                           m_d.byte_n = m_q.byte_n + 2'h1;
                           m_d.bit_n = 4'h0;
                           if (!m_q.rd) begin
                              m_d.sh = m_q.cmd;
                           end
                        end
                     end
                  end
               endcase
            end
            pscr_pkg::MS_STOP: begin
               unique case (m_q.phase)
                  2'h0: m_d.sda_oe = 1'b1;
                  2'h1: m_d.scl_oe = 1'b0;
                  2'h2: begin
                     if (!m_q.scl_s) begin
                        m_d.cnt = 8'h00;
                        m_d.phase = m_q.phase;
                     end else begin
                        m_d.sda_oe = 1'b0;
                     end
                  end
                  2'h3: begin
                     m_d.done = 1'b1;
                     m_d.state = pscr_pkg::MS_IDLE;
                     if (m_q.rd && !m_q.nack) begin
                        m_d.result = m_q.data[23:8];
                        m_d.crc_ok = pscr_pkg::pscr_crc16(m_q.data[23:8]) == m_q.data[7:0];
                     end
                  end
               endcase
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      m_q <= m_d;
   end
endmodule : pscr_master

/* File: logic/pscr_params.svh */
// Constants for the pressure sensor command and readout link
`ifndef PSCR_PARAMS_SVH
`define PSCR_PARAMS_SVH
`define PSCR_ADDR_DEFAULT 7'h40
`define PSCR_CMD_TRIGGER 8'hf1
`define PSCR_CMD_SOFT_RESET 8'hfe
`define PSCR_CRC_POLY 8'h31
`define PSCR_CRC_INIT 8'h00
`define PSCR_BYTE_BITS 4'h8
`define PSCR_CRC_BYTE_IDX 2'h2
`define PSCR_WR_LAST_BYTE 2'h1
`define PSCR_RD_LAST_BYTE 2'h3
`define PSCR_CLK_PERIOD_NS 8
`define PSCR_SCL_PERIOD_NS 2500
`define PSCR_QTR_CYC (((`PSCR_SCL_PERIOD_NS) / 4) / (`PSCR_CLK_PERIOD_NS))
`endif

/* File: logic/pscr_pkg.sv */
// Types and checksum function shared by both link ends
`include "pscr_params.svh"
package pscr_pkg;
   typedef enum logic [2:0] {
      SN_IDLE, SN_RX, SN_ACK, SN_WAIT, SN_TX, SN_TXACK, SN_IGNORE
   } pscr_sn_state_t;

   typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} pscr_ms_state_t;

   typedef struct packed {
      logic rst_m;
      logic rst_s;
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      logic [6:0] nvm_m;
      logic [6:0] nvm_s;
      logic done_m;
      logic done_s;
      logic done_p;
      logic [6:0] addr;
      logic need_load;
      pscr_sn_state_t state;
      logic is_cmd;
      logic is_read;
      logic acked;
      logic cmd_trig;
      logic [3:0] bit_cnt;
      logic [1:0] byte_cnt;
      logic [7:0] sh;
      logic [23:0] tx;
      logic meas_tgl;
      logic srst_tgl;
      logic sda_oe;
      logic scl_oe;
   } pscr_link_t;

   typedef struct packed {
      logic req_m;
      logic req_s;
      logic req_p;
      logic srst_m;
      logic srst_s;
      logic srst_p;
      logic busy;
      logic done_tgl;
      logic [15:0] res;
      logic meas_req;
      logic soft_rst;
   } pscr_sys_t;

   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic sda_m;
      logic sda_s;
      pscr_ms_state_t state;
      logic [1:0] phase;
      logic [7:0] cnt;
      logic [3:0] bit_n;
      logic [1:0] byte_n;
      logic rd;
      logic [7:0] cmd;
      logic [7:0] sh;
      logic [23:0] data;
      logic nack;
      logic scl_oe;
      logic sda_oe;
      logic done;
      logic [15:0] result;
      logic crc_ok;
   } pscr_master_t;

   function automatic logic [7:0] pscr_crc_byte(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ({c[6:0], 1'b0} ^ `PSCR_CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction : pscr_crc_byte

   function automatic logic [7:0] pscr_crc16(input logic [15:0] word);
      return pscr_crc_byte(pscr_crc_byte(`PSCR_CRC_INIT, word[15:8]), word[7:0]);
   endfunction : pscr_crc16
endpackage : pscr_pkg

/* File: logic/pscr_sensor.sv */
// Sensor end: command decode, measurement hold and result readout
`include "pscr_params.svh"

module pscr_sensor (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic LINK_CLK,
   input wire logic [6:0] NVM_ADDR,
   input wire logic MEAS_DONE,
   input wire logic signed [15:0] MEAS_DATA,
   output logic MEAS_REQ,
   output logic SOFT_RESET,
   pscr_if.sensor BUS
);
   pscr_pkg::pscr_link_t l_q;
   pscr_pkg::pscr_link_t l_d;
   pscr_pkg::pscr_sys_t c_q;
   pscr_pkg::pscr_sys_t c_d;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic new_result;

   assign scl_rise = l_q.scl_s & ~l_q.scl_p;
   assign scl_fall = ~l_q.scl_s & l_q.scl_p;
   assign bus_start = l_q.scl_s & l_q.scl_p & l_q.sda_p & ~l_q.sda_s;
   assign bus_stop = l_q.scl_s & l_q.scl_p & ~l_q.sda_p & l_q.sda_s;
   assign new_result = l_q.done_s ^ l_q.done_p;

   // Open-drain: only ever pull low
   assign BUS.scl_s_o = 1'b0;
   assign BUS.sda_s_o = 1'b0;
   assign BUS.scl_s_oe = l_q.scl_oe;
   assign BUS.sda_s_oe = l_q.sda_oe;
   assign MEAS_REQ = c_q.meas_req;
   assign SOFT_RESET = c_q.soft_rst;

   // Link side, on the link clock
   always_comb begin
      l_d = l_q;
      l_d.rst_m = RESET_N;
      l_d.rst_s = l_q.rst_m;
      l_d.scl_m = BUS.scl;
      l_d.scl_s = l_q.scl_m;
      l_d.scl_p = l_q.scl_s;
      l_d.sda_m = BUS.sda;
      l_d.sda_s = l_q.sda_m;
      l_d.sda_p = l_q.sda_s;
      l_d.nvm_m = NVM_ADDR;
      l_d.nvm_s = l_q.nvm_m;
      l_d.done_m = c_q.done_tgl;
      l_d.done_s = l_q.done_m;
      l_d.done_p = l_q.done_s;
      if (!l_q.rst_s) begin
         l_d.addr = `PSCR_ADDR_DEFAULT;
         l_d.need_load = 1'b1;
         l_d.state = pscr_pkg::SN_IDLE;
         l_d.is_cmd = 1'b0;
         l_d.is_read = 1'b0;
         l_d.acked = 1'b0;
         l_d.cmd_trig = 1'b0;
         l_d.bit_cnt = 4'h0;
         l_d.byte_cnt = 2'h0;
         l_d.sh = 8'h00;
         l_d.tx = 24'h000000;
         l_d.meas_tgl = 1'b0;
         l_d.srst_tgl = 1'b0;
         l_d.sda_oe = 1'b0;
         l_d.scl_oe = 1'b0;
      end else begin
         // Settings come from the nonvolatile store after any reset
         if (l_q.need_load) begin
            l_d.addr = l_q.nvm_s;
            l_d.need_load = 1'b0;
         end
         if (bus_start) begin
            l_d.state = pscr_pkg::SN_RX;
            l_d.is_cmd = 1'b0;
            l_d.bit_cnt = 4'h0;
            l_d.sda_oe = 1'b0;
            l_d.scl_oe = 1'b0;
         end else if (bus_stop) begin
            l_d.state = pscr_pkg::SN_IDLE;
            l_d.sda_oe = 1'b0;
            l_d.scl_oe = 1'b0;
         end else begin
            unique case (l_q.state)
               pscr_pkg::SN_IDLE, pscr_pkg::SN_IGNORE: begin
               end
               pscr_pkg::SN_RX: begin
                  if (scl_rise && l_q.bit_cnt != `PSCR_BYTE_BITS) begin
                     l_d.sh = {l_q.sh[6:0], l_q.sda_s};
                     l_d.bit_cnt = l_q.bit_cnt + 4'h1;
                  end else if (scl_fall && l_q.bit_cnt == `PSCR_BYTE_BITS) begin
                     l_d.state = pscr_pkg::SN_IGNORE;
                     if (!l_q.is_cmd) begin
                        // Read header refused unless a trigger is latched
                        if (l_q.sh[7:1] == l_q.addr && (!l_q.sh[0] || l_q.cmd_trig)) begin
                           l_d.is_read = l_q.sh[0];
                           l_d.sda_oe = 1'b1;
                           l_d.state = pscr_pkg::SN_ACK;
                        end
                     end else if (l_q.sh == `PSCR_CMD_TRIGGER) begin
                        l_d.cmd_trig = 1'b1;
                        l_d.sda_oe = 1'b1;
                        l_d.state = pscr_pkg::SN_ACK;
                     end else if (l_q.sh == `PSCR_CMD_SOFT_RESET) begin
                        l_d.cmd_trig = 1'b0;
                        l_d.need_load = 1'b1;
                        l_d.srst_tgl = ~l_q.srst_tgl;
                        l_d.sda_oe = 1'b1;
                        l_d.state = pscr_pkg::SN_ACK;
                     end
                  end
               end
               pscr_pkg::SN_ACK: begin
                  if (scl_fall) begin
                     l_d.sda_oe = 1'b0;
                     l_d.bit_cnt = 4'h0;
                     if (l_q.is_read) begin
                        l_d.scl_oe = 1'b1;
                        l_d.meas_tgl = ~l_q.meas_tgl;
                        l_d.state = pscr_pkg::SN_WAIT;
                     end else if (!l_q.is_cmd) begin
                        l_d.is_cmd = 1'b1;
                        l_d.state = pscr_pkg::SN_RX;
                     end else begin
                        // Further written bytes are not acknowledged
                        l_d.state = pscr_pkg::SN_IGNORE;
                     end
                  end
               end
               pscr_pkg::SN_WAIT: begin
                  if (new_result) begin
                     // First bit is set up while SCL is still held
                     l_d.tx = {c_q.res, pscr_pkg::pscr_crc16(c_q.res)};
                     l_d.sda_oe = ~c_q.res[15];
                     l_d.byte_cnt = 2'h0;
                     l_d.bit_cnt = 4'h0;
                     l_d.state = pscr_pkg::SN_TX;
                  end
               end
               pscr_pkg::SN_TX: begin
                  if (l_q.scl_oe) begin
                     l_d.scl_oe = 1'b0;
                  end else if (scl_fall) begin
                     l_d.tx = {l_q.tx[22:0], 1'b0};
                     if (l_q.bit_cnt == `PSCR_BYTE_BITS - 4'h1) begin
                        l_d.sda_oe = 1'b0;
                        l_d.bit_cnt = 4'h0;
                        l_d.state = pscr_pkg::SN_TXACK;
                     end else begin
                        l_d.sda_oe = ~l_q.tx[22];
                        l_d.bit_cnt = l_q.bit_cnt + 4'h1;
                     end
                  end
               end
               pscr_pkg::SN_TXACK: begin
                  if (scl_rise) begin
                     l_d.acked = ~l_q.sda_s;
                     if (l_q.sda_s) begin
                        l_d.state = pscr_pkg::SN_IGNORE;
                     end
                  end else if (scl_fall) begin
                     if (l_q.acked && l_q.byte_cnt != `PSCR_CRC_BYTE_IDX) begin
                        l_d.byte_cnt = l_q.byte_cnt + 2'h1;
                        l_d.sda_oe = ~l_q.tx[23];
                        l_d.state = pscr_pkg::SN_TX;
                     end else begin
                        l_d.state = pscr_pkg::SN_IGNORE;
                     end
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge LINK_CLK) begin
      l_q <= l_d;
   end

   // System side, on CLK
   always_comb begin
      c_d = c_q;
      c_d.req_m = l_q.meas_tgl;
      c_d.req_s = c_q.req_m;
      c_d.req_p = c_q.req_s;
      c_d.srst_m = l_q.srst_tgl;
      c_d.srst_s = c_q.srst_m;
      c_d.srst_p = c_q.srst_s;
      c_d.meas_req = 1'b0;
      c_d.soft_rst = 1'b0;
      if (!RESET_N) begin
         c_d.busy = 1'b0;
         c_d.done_tgl = 1'b0;
         c_d.res = 16'h0000;
      end else begin
         // Result is held stable until the next conversion completes
         if (c_q.busy && MEAS_DONE) begin
            c_d.res = MEAS_DATA;
            c_d.done_tgl = ~c_q.done_tgl;
            c_d.busy = 1'b0;
         end
         if (c_q.req_s ^ c_q.req_p) begin
            c_d.meas_req = 1'b1;
            c_d.busy = 1'b1;
         end
         if (c_q.srst_s ^ c_q.srst_p) begin
            c_d.soft_rst = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK) begin
      c_q <= c_d;
   end
endmodule : pscr_sensor

/* File: test/pscr_checker.sv */
// Timing checks on the open-drain link between the two ends
module pscr_checker (
   input wire logic CLK,
   input wire logic LINK_CLK,
   input wire logic RESET_N,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_s_oe,
   input wire logic sda_s_oe,
   input wire logic scl_m_oe,
   input wire logic sda_m_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] hold_q;

   // Length of the current clock stretch in link cycles
   always_ff @(posedge LINK_CLK) begin
      if (!RESET_N) begin
         hold_q <= 16'h0000;
      end else begin
         hold_q <= scl_s_oe ? hold_q + 16'h0001 : 16'h0000;
      end
   end

   chk_sda_moves_low: assert property (
      @(posedge LINK_CLK) disable iff (!RESET_N) $changed(sda_s_oe) |-> !scl && !$past(scl))
      else $error("sensor moved SDA while SCL high");
   chk_stretch_start_low: assert property (
      @(posedge LINK_CLK) disable iff (!RESET_N) $rose(scl_s_oe) |-> !scl && !$past(scl))
      else $error("sensor began stretch with SCL high");
   chk_stretch_release_high: assert property (
      @(posedge LINK_CLK) disable iff (!RESET_N) $fell(scl_s_oe) |-> scl)
      else $error("SCL did not rise at stretch release");
   chk_stretch_bounded: assert property (
      @(posedge LINK_CLK) disable iff (!RESET_N) hold_q < 16'h0258)
      else $error("clock stretch too long");
   chk_start_scl_high: assert property (
      @(posedge CLK) disable iff (!RESET_N) $rose(sda_m_oe) && scl |=> scl [*8])
      else $error("start condition too short");
   chk_stop_idle_after: assert property (
      @(posedge CLK) disable iff (!RESET_N) $fell(sda_m_oe) && scl |=> !sda_m_oe [*8])
      else $error("master drove SDA right after stop");
   chk_master_waits_scl: assert property (
      @(posedge CLK) disable iff (!RESET_N) !scl_m_oe && !scl |=> !scl_m_oe)
      else $error("master pulled SCL before it rose");
   chk_scl_low_phase: assert property (
      @(posedge CLK) disable iff (!RESET_N) $rose(scl_m_oe) |=> scl_m_oe [*8])
      else $error("SCL low phase too short");

   cover property (@(posedge LINK_CLK) disable iff (!RESET_N) $fell(scl_s_oe));
   cover property (@(posedge LINK_CLK) disable iff (!RESET_N) $rose(sda_s_oe));
   cover property (@(posedge CLK) disable iff (!RESET_N) $rose(sda_m_oe) && scl);
endmodule : pscr_checker

/* File: test/testbench.sv */
// Bench joining the master end to the sensor end over the link
`include "pscr_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] wr_hdr = {`PSCR_ADDR_DEFAULT, 1'b0};
   localparam logic [7:0] rd_hdr = {`PSCR_ADDR_DEFAULT, 1'b1};
   logic CLK, LINK_CLK, RESET_N, MEAS_DONE, MEAS_REQ, SOFT_RESET;
   logic REQ_VALID, REQ_READ, REQ_READY, DONE, NACK, CRC_OK;
   logic [6:0] NVM_ADDR;
   logic [7:0] REQ_CMD;
   logic signed [15:0] MEAS_DATA, RESULT;
   logic [15:0] meas_val;
   logic [7:0] sh;
   logic [8:0] wire_log[$];
   int error_cnt = 0, tests_run = 0, meas_cnt = 0, srst_cnt = 0, meas_delay = 300, bitn = 0;

   pscr_if bus ();
   pscr_sensor pscr_sensor_i (.CLK(CLK), .RESET_N(RESET_N), .LINK_CLK(LINK_CLK),
      .NVM_ADDR(NVM_ADDR), .MEAS_DONE(MEAS_DONE), .MEAS_DATA(MEAS_DATA),
      .MEAS_REQ(MEAS_REQ), .SOFT_RESET(SOFT_RESET), .BUS(bus));
   pscr_master pscr_master_i (.CLK(CLK), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID),
      .REQ_READ(REQ_READ), .REQ_CMD(REQ_CMD), .REQ_READY(REQ_READY), .DONE(DONE),
      .NACK(NACK), .RESULT(RESULT), .CRC_OK(CRC_OK), .BUS(bus));
   pscr_checker pscr_checker_i (.CLK(CLK), .LINK_CLK(LINK_CLK), .RESET_N(RESET_N),
      .scl(bus.scl), .sda(bus.sda), .scl_s_oe(bus.scl_s_oe), .sda_s_oe(bus.sda_s_oe),
      .scl_m_oe(bus.scl_m_oe), .sda_m_oe(bus.sda_m_oe));

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   initial begin
      LINK_CLK = 1'b0;
      #3.3;
      forever #7.5 LINK_CLK = ~LINK_CLK;
   end

   // Measurement source answering each conversion request after a delay
   initial begin
      MEAS_DONE = 1'b0;
      MEAS_DATA = 16'h0000;
      forever begin
         @(posedge CLK);
         if (MEAS_REQ === 1'b1) begin
            meas_cnt++;
            repeat (meas_delay) @(posedge CLK);
            MEAS_DATA <= meas_val;
            MEAS_DONE <= 1'b1;
            @(posedge CLK);
            MEAS_DONE <= 1'b0;
            MEAS_DATA <= ~meas_val;
         end
      end
   end
   always @(posedge CLK) begin
      if (SOFT_RESET === 1'b1) begin
         srst_cnt++;
      end
   end

   // Wire monitor: byte and acknowledge bit of every frame, MSB first
   always @(negedge bus.sda) begin
      if (bus.scl === 1'b1) begin
         bitn = 0;
      end
   end
   always @(posedge bus.scl) begin
      if (bitn == 8) begin
         wire_log.push_back({sh, bus.sda});
         bitn = 0;
      end else begin
         sh = {sh[6:0], bus.sda};
         bitn++;
      end
   end

   function automatic logic [7:0] crc_calc(input logic [15:0] w);
      logic [7:0] c;
      c = `PSCR_CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ `PSCR_CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc_calc

   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wire_chk(input logic [8:0] exp[$]);
      check("frame count", exp.size(), wire_log.size());
      foreach (exp[i]) begin
         if (i < wire_log.size()) begin
            check("frame", exp[i], wire_log[i]);
         end
      end
   endtask : wire_chk

   task automatic xfer(input logic rd, input logic [7:0] cmd);
      logic rdy;
      int n;
      wire_log.delete();
      n = 0;
      rdy = 1'b0;
      @(posedge CLK);
      REQ_VALID <= 1'b1;
      REQ_READ <= rd;
      REQ_CMD <= cmd;
      while (rdy !== 1'b1 && n < 100) begin
         @(negedge CLK);
         rdy = REQ_READY;
         @(posedge CLK);
         n++;
      end
      if (rdy !== 1'b1) begin
         error_cnt++;
         $display("BAD ready expected 1 seen %b", rdy);
         complete_run();
      end
      REQ_VALID <= 1'b0;
      n = 0;
      rdy = 1'b0;
      while (rdy !== 1'b1 && n < 40000) begin
         @(posedge CLK);
         #1;
         rdy = DONE;
         n++;
      end
      if (rdy !== 1'b1) begin
         error_cnt++;
         $display("BAD done expected 1 seen %b", rdy);
         complete_run();
      end
   endtask : xfer

   task automatic read_ok(input logic [15:0] val, input int dly, input int cnt);
      meas_val = val;
      meas_delay = dly;
      xfer(1'b1, 8'h00);
      check("read nack", 32'h0, NACK);
      check("result", val, RESULT[15:0]);
      check("crc ok", 32'h1, CRC_OK);
      check("conversions", cnt, meas_cnt);
      wire_chk('{{rd_hdr, 1'b0}, {val[15:8], 1'b0}, {val[7:0], 1'b0}, {crc_calc(val), 1'b1}});
      $display("test read %h done", val);
   endtask : read_ok

   task automatic write_cmd(input logic [7:0] cmd, input logic nak);
      xfer(1'b0, cmd);
      check("write nack", nak, NACK);
      wire_chk('{{wr_hdr, 1'b0}, {cmd, nak}});
      $display("test write %h done", cmd);
   endtask : write_cmd

   task automatic read_refused(input string what);
      xfer(1'b1, 8'h00);
      check("refused nack", 32'h1, NACK);
      check("no conversion", 32'h2, meas_cnt);
      wire_chk('{{rd_hdr, 1'b1}});
      $display("test %s done", what);
   endtask : read_refused

   task automatic do_reset();
      @(posedge CLK);
      RESET_N <= 1'b0;
      repeat (6) @(posedge LINK_CLK);
      @(posedge CLK);
      NVM_ADDR <= `PSCR_ADDR_DEFAULT;
      @(posedge CLK);
      RESET_N <= 1'b1;
   endtask : do_reset

   initial begin
      RESET_N = 1'b0;
      REQ_VALID = 1'b0;
      REQ_READ = 1'b0;
      REQ_CMD = 8'h00;
      NVM_ADDR = `PSCR_ADDR_DEFAULT;
      meas_val = 16'h0000;
      do_reset();
      write_cmd(`PSCR_CMD_TRIGGER, 1'b0);
      read_ok(16'h8a3c, 300, 1);
      read_ok(16'h17c5, 500, 2);
      write_cmd(8'h5a, 1'b1);
      @(posedge CLK);
      NVM_ADDR <= 7'h41;
      write_cmd(`PSCR_CMD_SOFT_RESET, 1'b0);
      check("soft reset pulses", 32'h1, srst_cnt);
      read_refused("reloaded address");
      check("result kept", 32'h17c5, RESULT[15:0]);
      do_reset();
      read_refused("read without trigger");
      write_cmd(`PSCR_CMD_TRIGGER, 1'b0);
      read_ok(16'h7fff, 300, 3);
      complete_run();
   end
endmodule : testbench
